/* File: logic/adcsr_params.svh */
`ifndef ADCSR_PARAMS_SVH
`define ADCSR_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ADCSR_CLK_NS        40
`define ADCSR_TIMEOUT_NS    30800000
`define ADCSR_TIMEOUT_CYC   \
  ((`ADCSR_TIMEOUT_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS)
`define ADCSR_DROP_NS       8000
`define ADCSR_DROP_CYC      (`ADCSR_DROP_NS / `ADCSR_CLK_NS)
`define ADCSR_CONV_NS       976563
`define ADCSR_CONV_CYC      (`ADCSR_CONV_NS / `ADCSR_CLK_NS)

// ----------------------------------------------------------------
// Transfer framing
// ----------------------------------------------------------------
`define ADCSR_XFER_HALF     6'd24
`define ADCSR_XFER_FULL     6'd48

// ----------------------------------------------------------------
// Configuration word
// ----------------------------------------------------------------
`define ADCSR_CFG_RST       24'h058b20
`define ADCSR_CFG_WR_MASK   24'h7ffee0
`define ADCSR_CFG_RSV1      24'h000100
`define ADCSR_CFG_SS_BIT    23
`define ADCSR_CFG_MODE_BIT  16
`define ADCSR_CFG_PULL_BIT  11
`define ADCSR_KEY_HI        10
`define ADCSR_KEY_LO        9
`define ADCSR_KEY_VALID     2'h1

// ----------------------------------------------------------------
// Result coding
// ----------------------------------------------------------------
`define ADCSR_RES_MAX       24'h7fffff
`define ADCSR_RES_MIN       24'h800000
`define ADCSR_SAT_HI        28'sh07fffff
`define ADCSR_SAT_LO        28'shf800000

`endif

/* File: logic/adcsr_pkg.sv */
package adcsr_pkg;

  typedef enum logic {
    ADCSR_IDLE,
    ADCSR_CONV
  } adcsr_phase_t;

  typedef struct packed {
    adcsr_phase_t phase;
    logic [19:0]  cnt;
    logic         done;
    logic         drop;
    logic [23:0]  result;
  } adcsr_seq_st_t;

  typedef struct packed {
    logic        sclk_d;
    logic        in_xfer;
    logic [5:0]  rise_cnt;
    logic [5:0]  fall_cnt;
    logic [19:0] low_cnt;
    logic [23:0] sh;
    logic        out;
    logic [23:0] din_sh;
    logic [23:0] cfg;
    logic        ss_start;
    logic        new_data;
    logic        dout;
    logic        oe;
    logic        pull;
  } adcsr_ser_st_t;

endpackage

/* File: logic/adcsr_conv_if.sv */
interface adcsr_conv_if;
  logic        mode_single;
  logic        ss_start;
  logic        busy;
  logic        conv_done;
  logic        ready_drop;
  logic [23:0] result;

  modport ctl (
    output mode_single,
    output ss_start,
    input  busy,
    input  conv_done,
    input  ready_drop,
    input  result
  );

  modport seq (
    input  mode_single,
    input  ss_start,
    output busy,
    output conv_done,
    output ready_drop,
    output result
  );
endinterface

/* File: logic/adcsr_pin_sync.sv */
module adcsr_pin_sync #(
  parameter int         W   = 3,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adcsr_sync_st_t;

  adcsr_sync_st_t st;
  adcsr_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st.s1 <= RST;
      st.s2 <= RST;
    end else begin
      st <= st_nxt;
    end
  end

  assign sync_out = st.s2;
endmodule

/* File: logic/adcsr_conv_seq.sv */
`include "adcsr_params.svh"

module adcsr_conv_seq
  import adcsr_pkg::*;
#(
  parameter int CONV_CYC = `ADCSR_CONV_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic signed [27:0] filter_sample,
  adcsr_conv_if.seq               cv
);
  localparam logic [19:0] PER_M1  = 20'(CONV_CYC - 1);
  localparam logic [19:0] DROP_AT = 20'(CONV_CYC - 1 - `ADCSR_DROP_CYC);

  adcsr_seq_st_t st;
  adcsr_seq_st_t st_nxt;

  // ----------------------------------------------------------------
  // Clipping to full scale
  // ----------------------------------------------------------------
  function automatic logic [23:0] clip(input logic signed [27:0] s);
    if (s > `ADCSR_SAT_HI) begin
      return `ADCSR_RES_MAX;
    end else if (s < `ADCSR_SAT_LO) begin
      return `ADCSR_RES_MIN;
    end else begin
      return s[23:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st;
    st_nxt.done = 1'b0;
    st_nxt.drop = 1'b0;
    unique case (st.phase)
      ADCSR_IDLE: begin
        if (!cv.mode_single || cv.ss_start) begin
          st_nxt.phase = ADCSR_CONV;
          st_nxt.cnt   = '0;
        end
      end
      ADCSR_CONV: begin
        st_nxt.cnt = st.cnt + 20'd1;
        if (st.cnt == DROP_AT) begin
          st_nxt.drop = !cv.mode_single;
        end
        if (st.cnt == PER_M1) begin
          st_nxt.done   = 1'b1;
          st_nxt.result = clip(filter_sample);
          st_nxt.cnt    = '0;
          if (cv.mode_single) begin
            st_nxt.phase = ADCSR_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  assign cv.busy       = (st.phase == ADCSR_CONV);
  assign cv.conv_done  = st.done;
  assign cv.ready_drop = st.drop;
  assign cv.result     = st.result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_drop_before_ready: assert property (
    cv.ready_drop |-> ##200 cv.conv_done)
    else $error("ready release not 8 us before next result");

  a_single_waits: assert property (
    cv.mode_single && !cv.busy && !cv.ss_start |=> !cv.busy)
    else $error("conversion began without a start request");

  a_cont_running: assert property (
    !cv.mode_single && !cv.busy |=> cv.busy)
    else $error("continuous mode left the converter idle");

  a_result_clipped: assert property (
    st_nxt.done && (filter_sample > `ADCSR_SAT_HI)
      |=> cv.result == `ADCSR_RES_MAX)
    else $error("positive overrange not clipped");
endmodule

/* File: logic/adcsr_serial.sv */
`include "adcsr_params.svh"

// Operation
// - Chip select high: interface reset, pin undriven.
// - Chip select falls: pin shows ready state.
// - Result frozen in shifter during transfer.
// - Long SCLK low resets serial interface.
// - DIN sampled on falling SCLK, never driven.
// - Output pin advances on rising SCLK.
// - Completed conversion pulls ready pin low.
// - Continuous mode: pin released 8 us early.
// - Chip select high: weak pull-up if enabled.
// - Results saturate at 24-bit full scale.
// - Continuous mode converts regardless of select.
// - Single-shot converts only on start bit.
// - Bit 23 first; config shifts in meanwhile.
// - Cycles are 48 or 24 bits.
// - 48-bit cycle reads back written configuration.
// - 24-bit cycle ends by chip select rise.
// - No new result: same result resent.
// - Configuration written only with valid key.
// - Mode bit selects continuous or single-shot.
module adcsr_serial
  import adcsr_pkg::*;
#(
  parameter int TIMEOUT_CYC = `ADCSR_TIMEOUT_CYC,
  parameter int CONV_CYC    = `ADCSR_CONV_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               cs_n,
  input  wire logic               sclk,
  input  wire logic               din,
  output logic                    data_out_ready_n,
  output logic                    data_out_ready_oe,
  output logic                    output_weak_pull_enable,
  input  wire logic signed [27:0] filter_sample,
  output logic             [23:0] config_word,
  output logic                    conv_busy
);
  localparam logic [19:0] TO_M1 = 20'(TIMEOUT_CYC - 1);

  adcsr_ser_st_t st;
  adcsr_ser_st_t st_nxt;
  logic [2:0]    pins_q;
  logic          cs_q;
  logic          sclk_q;
  logic          din_q;
  logic          rise;
  logic          fall;
  logic          tmo;
  logic [23:0]   word;

  adcsr_conv_if cv ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  adcsr_pin_sync #(
    .W   (3),
    .RST (3'h4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({cs_n, sclk, din}),
    .sync_out (pins_q)
  );

  assign cs_q   = pins_q[2];
  assign sclk_q = pins_q[1];
  assign din_q  = pins_q[0];

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  adcsr_conv_seq #(
    .CONV_CYC (CONV_CYC)
  ) u_seq (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .filter_sample (filter_sample),
    .cv            (cv)
  );

  assign cv.mode_single = st.cfg[`ADCSR_CFG_MODE_BIT];
  assign cv.ss_start    = st.ss_start;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st;
    st_nxt.sclk_d   = sclk_q;
    st_nxt.ss_start = 1'b0;
    rise            = sclk_q & ~st.sclk_d;
    fall            = ~sclk_q & st.sclk_d;
    word            = {st.din_sh[22:0], din_q};

    // SCLK-low watchdog
    if (sclk_q) begin
      st_nxt.low_cnt = '0;
    end else if (st.low_cnt != TO_M1) begin
      st_nxt.low_cnt = st.low_cnt + 20'd1;
    end
    tmo = !sclk_q && (st_nxt.low_cnt == TO_M1) && (st.low_cnt != TO_M1);

    if (cs_q || tmo) begin
      st_nxt.in_xfer  = 1'b0;
      st_nxt.rise_cnt = '0;
      st_nxt.fall_cnt = '0;
    end else begin
      if (rise) begin
        if (!st.in_xfer) begin
          // Freeze current result, old one if nothing new
          st_nxt.sh       = cv.result;
          st_nxt.out      = cv.result[23];
          st_nxt.in_xfer  = 1'b1;
          st_nxt.rise_cnt = 6'd1;
          st_nxt.new_data = 1'b0;
        end else if (st.rise_cnt == `ADCSR_XFER_HALF) begin
          st_nxt.sh       = st.cfg;
          st_nxt.out      = st.cfg[23];
          st_nxt.rise_cnt = st.rise_cnt + 6'd1;
        end else begin
          st_nxt.sh       = {st.sh[22:0], 1'b0};
          st_nxt.out      = st.sh[22];
          st_nxt.rise_cnt = st.rise_cnt + 6'd1;
        end
      end
      if (fall && st.in_xfer) begin
        st_nxt.din_sh   = word;
        st_nxt.fall_cnt = st.fall_cnt + 6'd1;
        if (st.fall_cnt == `ADCSR_XFER_HALF - 6'd1 &&
            word[`ADCSR_KEY_HI:`ADCSR_KEY_LO] == `ADCSR_KEY_VALID) begin
          // SS is a strobe and never stored
          st_nxt.cfg      = (word & `ADCSR_CFG_WR_MASK) |
                            `ADCSR_CFG_RSV1;
          st_nxt.ss_start = word[`ADCSR_CFG_SS_BIT];
        end
        if (st.fall_cnt == `ADCSR_XFER_FULL - 6'd1) begin
          st_nxt.in_xfer  = 1'b0;
          st_nxt.rise_cnt = '0;
          st_nxt.fall_cnt = '0;
        end
      end
    end

    // Ready flag: a completing conversion wins over any clear
    if (cv.ready_drop && !st.in_xfer) begin
      st_nxt.new_data = 1'b0;
    end
    if (cv.conv_done) begin
      st_nxt.new_data = 1'b1;
    end

    st_nxt.dout = st_nxt.in_xfer ? st_nxt.out : ~st_nxt.new_data;
    st_nxt.oe   = ~cs_q;
    st_nxt.pull = cs_q & st_nxt.cfg[`ADCSR_CFG_PULL_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st      <= '0;
      st.cfg  <= `ADCSR_CFG_RST;
      st.dout <= 1'b1;
      st.pull <= 1'b1;
    end else begin
      st <= st_nxt;
    end
  end

  assign data_out_ready_n        = st.dout;
  assign data_out_ready_oe       = st.oe;
  assign output_weak_pull_enable = st.pull;
  assign config_word             = st.cfg;
  assign conv_busy               = cv.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_start_bit;
    rise && !cs_q && !st.in_xfer;
  endsequence

  sequence s_mid_bit;
    rise && !cs_q && st.in_xfer && (st.rise_cnt < `ADCSR_XFER_HALF);
  endsequence

  a_cs_high_float: assert property (
    cs_q |=> !data_out_ready_oe && !st.in_xfer)
    else $error("pin driven or transfer alive with select high");

  a_select_ready: assert property (
    data_out_ready_oe && !st.in_xfer |-> data_out_ready_n == !st.new_data)
    else $error("ready level wrong while selected and idle");

  a_frozen_shift: assert property (
    st.in_xfer && !rise && !cs_q |=> $stable(st.sh))
    else $error("output shifter changed between edges");

  a_timeout_reset: assert property (
    !cs_q && !sclk_q && st.low_cnt == TO_M1 - 20'd1 |=> !st.in_xfer)
    else $error("watchdog did not reset the interface");

  a_din_on_fall: assert property (
    fall && st.in_xfer && !cs_q && !tmo |=> st.din_sh[0] == $past(din_q))
    else $error("DIN not taken on falling SCLK");

  a_msb_first: assert property (
    s_start_bit |=> data_out_ready_n == $past(cv.result[23]))
    else $error("first bit is not result bit 23");

  a_shift_on_rise: assert property (
    s_mid_bit |=> data_out_ready_n == $past(st.sh[22]))
    else $error("pin did not advance on rising SCLK");

  a_ready_set: assert property (
    cv.conv_done |=> st.new_data)
    else $error("new result not flagged");

  a_read_clears: assert property (
    s_start_bit ##0 !cv.conv_done |=> !st.new_data)
    else $error("read result still flagged new");

  a_key_gate: assert property (
    fall && st.in_xfer && !cs_q &&
    st.fall_cnt == `ADCSR_XFER_HALF - 6'd1 &&
    word[`ADCSR_KEY_HI:`ADCSR_KEY_LO] != `ADCSR_KEY_VALID
      |=> $stable(st.cfg))
    else $error("configuration changed without valid key");

  a_readback_load: assert property (
    rise && !cs_q && st.in_xfer && st.rise_cnt == `ADCSR_XFER_HALF
      |=> data_out_ready_n == $past(st.cfg[23]))
    else $error("readback does not start with config bit 23");

  a_pull_follows: assert property (
    cs_q |=> output_weak_pull_enable == st.cfg[`ADCSR_CFG_PULL_BIT])
    else $error("weak pull enable wrong while deselected");

  sequence s_key_fall;
    fall && st.in_xfer && !cs_q && !tmo &&
    st.fall_cnt == `ADCSR_XFER_HALF - 6'd1 &&
    word[`ADCSR_KEY_HI:`ADCSR_KEY_LO] == `ADCSR_KEY_VALID;
  endsequence

  sequence s_last_fall;
    fall && st.in_xfer && !cs_q && !tmo &&
    st.fall_cnt == `ADCSR_XFER_FULL - 6'd1;
  endsequence

  a_frame_end: assert property (
    s_last_fall |=> !st.in_xfer && st.rise_cnt == '0 &&
      data_out_ready_n == !st.new_data)
    else $error("long frame did not close after its last bit");

  a_cfg_write: assert property (
    s_key_fall |=> config_word ==
      (($past(word) & `ADCSR_CFG_WR_MASK) | `ADCSR_CFG_RSV1))
    else $error("valid configuration word not stored");

  a_ss_strobe: assert property (
    s_key_fall ##0 word[`ADCSR_CFG_SS_BIT] |=> cv.ss_start)
    else $error("start request not passed on");

  a_ss_source: assert property (
    cv.ss_start |-> $past(fall && st.in_xfer && !cs_q &&
      st.fall_cnt == `ADCSR_XFER_HALF - 6'd1))
    else $error("start strobe without a written word");

  a_cfg_fixed_bits: assert property (
    (config_word & ~`ADCSR_CFG_WR_MASK) == `ADCSR_CFG_RSV1)
    else $error("reserved configuration bits wrong");

  a_sclk_ignored: assert property (
    cs_q |=> st.rise_cnt == '0 && st.fall_cnt == '0)
    else $error("SCLK counted with select high");

  a_select_level: assert property (
    $fell(cs_q) && !rise |=> data_out_ready_oe &&
      data_out_ready_n == !st.new_data)
    else $error("select fall did not show ready level");

  a_timeout_fresh: assert property (
    tmo |=> !st.in_xfer && st.rise_cnt == '0 && st.fall_cnt == '0)
    else $error("watchdog left counters running");

  a_drop_clears: assert property (
    cv.ready_drop && !st.in_xfer && !cv.conv_done |=> !st.new_data)
    else $error("ready not released before next result");

  a_pin_holds: assert property (
    st.in_xfer && !rise && !fall && !cs_q && !tmo
      |=> $stable(data_out_ready_n))
    else $error("pin moved without a rising SCLK");

  a_resend_frozen: assert property (
    s_start_bit |=> st.sh == $past(cv.result))
    else $error("transfer did not take the buffered result");

  a_readback_shift: assert property (
    rise && !cs_q && st.in_xfer && st.rise_cnt > `ADCSR_XFER_HALF
      |=> data_out_ready_n == $past(st.sh[22]))
    else $error("readback bit out of order");

  a_pull_selected: assert property (
    !cs_q |=> !output_weak_pull_enable)
    else $error("weak pull left on while selected");
endmodule

/* File: verification/adcsr_host_model.sv */
module adcsr_host_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic pin,
  input  wire logic pin_oe,
  input  wire logic pin_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b1;
  end

  task automatic select(input logic lvl);
    cs_n = lvl;
  endtask

  // Line level: pulled up, or drifting away when released unpulled
  function automatic logic bus_level();
    return pin_oe ? pin : (pin_pull ? 1'b1 : ~pin);
  endfunction

  // ----------------------------------------
  // One frame, 320 ns per bit
  // ----------------------------------------
  task automatic xfer(input int n, input logic [47:0] w, input logic hold,
                      output logic rdy, output logic [47:0] r);
    r = '0;
    #13;
    cs_n = 1'b0;
    #320;
    rdy = bus_level();
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din  = w[47-i];
      #160;
      // Taken at the fall: the last bit of a frame ends there
      r    = {r[46:0], bus_level()};
      sclk = 1'b0;
      #160;
    end
    if (!hold) begin
      cs_n = 1'b1;
      din  = ~din;
    end
    #320;
  endtask
endmodule

/* File: verification/adcsr_serial_tb.sv */
module adcsr_serial_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adcsr_pkg::*;

  localparam int TO = 64;
  localparam int CC = 400;

  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic               cs_n;
  logic               sclk;
  logic               din;
  logic               pin;
  logic               oe;
  logic               pull;
  logic               busy;
  logic        [23:0] cfg;
  logic signed [27:0] sample = '0;
  logic signed [27:0] corner [4] = '{28'sh7ffffff, 28'sh8000000,
                                     28'sh07fffff, 28'shf800000};
  int                 num_errors = 0;
  int                 total_checks = 0;

  always #20 clk_sys = ~clk_sys;

  adcsr_serial #(.TIMEOUT_CYC(TO), .CONV_CYC(CC)) u_adcsr_serial (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .din(din), .data_out_ready_n(pin), .data_out_ready_oe(oe),
    .output_weak_pull_enable(pull), .filter_sample(sample),
    .config_word(cfg), .conv_busy(busy)
  );

  adcsr_host_model u_adcsr_host_model (
    .cs_n(cs_n), .sclk(sclk), .din(din), .pin(pin), .pin_oe(oe),
    .pin_pull(pull)
  );

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [23:0] sat(input logic signed [27:0] s);
    if (s > 28'sh07fffff) return 24'h7fffff;
    if (s < 28'shf800000) return 24'h800000;
    return s[23:0];
  endfunction

  function automatic logic [23:0] stored(input logic [23:0] w);
    return (w & 24'h7ffee0) | 24'h000100;
  endfunction

  function automatic logic [23:0] word(input logic ss, input logic mode,
                                       input logic [1:0] key);
    logic [23:0] w;
    w = 24'($urandom);
    w[23] = ss;
    w[16] = mode;
    w[10:9] = key;
    return w;
  endfunction

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic summarize;
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for pin (sel 0) or busy (sel 1) to reach a level
  task automatic wait_for(input int sel, input logic want, input int lim,
                          output int n);
    n = 0;
    while ((sel ? busy : pin) !== want) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("ERROR wait expected %h seen %h", want, sel ? busy : pin);
        summarize();
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic        rdy;
    logic [47:0] r;
    logic [23:0] w;
    logic [23:0] ec;
    logic [23:0] er;
    int          n;
    void'($urandom(63));
    ec = 24'h058b20;
    er = '0;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    chk("config_word", ec, cfg);
    chk("pull", 24'(1), 24'(pull));
    // Every key code, config sent twice in a 48-bit frame
    for (int k = 0; k < 8; k++) begin
      w = word(1'b0, 1'b1, 2'(k));
      u_adcsr_host_model.xfer(48, {w, w}, 1'b0, rdy, r);
      if (k % 4 == 1) ec = stored(w);
      chk("rdy", 24'(1), 24'(rdy));
      chk("result", er, r[47:24]);
      chk("readback", ec, r[23:0]);
      chk("config_word", ec, cfg);
      chk("oe", 24'(0), 24'(oe));
      chk("pull", 24'(ec[11]), 24'(pull));
      chk("conv_busy", 24'(0), 24'(busy));
    end
    // Single-shot conversions, corners then random
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      sample <= (i < 4) ? corner[i] : 28'($urandom);
      w = word(1'b1, 1'b1, 2'h1);
      u_adcsr_host_model.xfer(24, {w, 24'h0}, 1'b0, rdy, r);
      ec = stored(w);
      er = sat(sample);
      chk("config_word", ec, cfg);
      chk("conv_busy", 24'(1), 24'(busy));
      wait_for(1, 1'b0, CC + 20, n);
      #8000;
      u_adcsr_host_model.xfer(24, '1, 1'b0, rdy, r);
      chk("rdy", 24'(0), 24'(rdy));
      chk("result", er, r[23:0]);
      u_adcsr_host_model.xfer(24, '1, 1'b0, rdy, r);
      chk("rdy", 24'(1), 24'(rdy));
      chk("result", er, r[23:0]);
    end
    // Broken frame left with SCLK low past the time-out
    u_adcsr_host_model.xfer(5, '1, 1'b1, rdy, r);
    #4000;
    u_adcsr_host_model.xfer(48, '1, 1'b0, rdy, r);
    chk("result", er, r[47:24]);
    chk("readback", ec, r[23:0]);
    // Continuous mode, select high while converting
    w = word(1'b0, 1'b0, 2'h1);
    u_adcsr_host_model.xfer(24, {w, 24'h0}, 1'b0, rdy, r);
    wait_for(1, 1'b1, CC, n);
    u_adcsr_host_model.select(1'b0);
    wait_for(0, 1'b0, 2 * CC, n);
    wait_for(0, 1'b1, CC, n);
    chk("low_time", 24'(1), 24'(n >= CC - 202 && n <= CC - 198));
    wait_for(0, 1'b0, CC, n);
    chk("high_time", 24'(1), 24'(n >= 198 && n <= 202));
    er = sat(sample);
    @(negedge clk_sys);
    sample <= 28'($urandom);
    repeat (280) @(negedge clk_sys);
    // This read straddles the next conversion end
    u_adcsr_host_model.xfer(24, '0, 1'b0, rdy, r);
    chk("frozen", er, r[23:0]);
    u_adcsr_host_model.xfer(24, '1, 1'b0, rdy, r);
    chk("rdy", 24'(0), 24'(rdy));
    chk("result", sat(sample), r[23:0]);
    summarize();
  end
endmodule
